// [inc/phy_lpm_params.svh]
// offsets, field positions, reset values and timing counts of the link ends
`ifndef PHY_LPM_PARAMS_SVH
`define PHY_LPM_PARAMS_SVH

// management register numbers on the device side
`define REG_BASIC_CTRL   5'h00
`define REG_DIG_CTRL     5'h10
`define REG_AFE_CTRL     5'h11
`define REG_EXP_CTRL     5'h18
`define REG_PHY_CTRL2    5'h1f

// field positions
`define BIT_SOFT_RESET   15
`define BIT_AUTONEG      12
`define BIT_POWER_DOWN   11
`define BIT_PLL_OFF      4
`define BIT_SLOW_OSC     5
`define BIT_EDM_DIS      11
`define BIT_PWR_SAVE     10

// reset values
`define RST_AUTONEG      1'b1
`define RST_POWER_DOWN   1'b0
`define RST_PLL_OFF      1'b0
`define RST_SLOW_OSC     1'b0
`define RST_EDM_DIS      1'b1
`define RST_PWR_SAVE     1'b0

// timing
`define CLK_HZ           20000000
`define CYC_PER_US       (`CLK_HZ / 1000000)
`define LP_SHORT_US      16
`define LP_LONG_US       64
`define WAKE_US          200
`define LP_SHORT_CYC     (`LP_SHORT_US * `CYC_PER_US)
`define LP_LONG_CYC      (`LP_LONG_US * `CYC_PER_US)
`define WAKE_CYC         (`WAKE_US * `CYC_PER_US)
`define SRST_CYC         4

// controller registers on apb
`define APB_CMD_ADDR     12'h000
`define APB_CMD_WDATA    12'h004
`define APB_CTRL         12'h008
`define APB_STATUS       12'h00c
`define APB_RDATA        12'h010
`define CTRL_START       0
`define CTRL_WRITE       1
`define STAT_BUSY        0
`define STAT_DONE        1

`endif

// [inc/phy_lpm_pkg.sv]
// types shared by the two ends of the management link
package phy_lpm_pkg;

  typedef logic [4:0]  mgmt_addr_t;
  typedef logic [15:0] mgmt_data_t;
  typedef logic [19:0] cnt_t;

  typedef enum logic [0:0] {
    H_IDLE = 1'b0,
    H_WAIT = 1'b1
  } host_state_e;

  typedef struct packed {
    logic       ack;
    mgmt_data_t rdata;
    logic       an_en;
    logic       pd;
    logic       pll_off;
    logic       slow;
    logic       edm_dis;
    logic       ps_en;
    logic       srst;
    logic [3:0] srst_cnt;
    logic       wake;
    cnt_t       wake_cnt;
    cnt_t       lp_cnt;
    logic       link_pulse;
    logic       rx_pwr;
    logic       tx_pwr;
    logic       ed_pwr;
    logic       pll_pwr;
    logic       func_en;
    logic       slow_sel;
    logic       soft_reset;
    logic       ps_act;
    logic       edm_act;
  } dev_state_s;

  typedef struct packed {
    host_state_e state;
    logic        req;
    logic        we;
    mgmt_addr_t  addr;
    mgmt_data_t  wdata;
    mgmt_addr_t  cmd_addr;
    mgmt_data_t  cmd_wdata;
    mgmt_data_t  rdata;
    logic        done;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } host_state_s;

endpackage

// [inc/mgmt_if.sv]
// register access link between management controller and transceiver
interface mgmt_if;
  logic                    req;
  logic                    we;
  phy_lpm_pkg::mgmt_addr_t addr;
  phy_lpm_pkg::mgmt_data_t wdata;
  logic                    ack;
  phy_lpm_pkg::mgmt_data_t rdata;

  modport device (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface

// [core/phy_lpm_device.sv]
// transceiver low-power mode control behind the management link
//
// Overview of operation
// - power saving enabled only by control bit
// - power saving needs autoneg on, no link
// - power saving keeps tx, energy detect, pll
// - power saving control resets disabled
// - energy-detect power-down enabled by zero bit
// - pll stops in energy-detect mode when set
// - periodic link pulses during energy-detect mode
// - energy-detect control resets to mode off
// - power-down entered by writing bit one
// - power-down keeps only management alive
// - power-down left when bit written zero
// - slow oscillator bit switches clock source
// - slow oscillator plus power-down lowest power
// - exit: clear osc, clear pd, reset
// - software reset bit clears itself
`include "phy_lpm_params.svh"

module phy_lpm_device #(
  parameter int LP_SHORT = `LP_SHORT_CYC,
  parameter int LP_LONG  = `LP_LONG_CYC,
  parameter int WAKE     = `WAKE_CYC,
  parameter int SRST     = `SRST_CYC
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  mgmt_if.device     mgmt,
  input  wire logic  link_up,
  input  wire logic  energy_detect,
  output logic       rx_power_en,
  output logic       tx_power_en,
  output logic       energy_det_power_en,
  output logic       pll_power_en,
  output logic       core_func_en,
  output logic       slow_osc_sel,
  output logic       link_pulse,
  output logic       soft_reset,
  output logic       power_saving_active,
  output logic       energy_detect_power_down
);

  // refused at elaboration: the counters are 20 and 4 bits wide
  if (LP_SHORT < 2 || LP_LONG < 2 || WAKE < 2 ||
      LP_SHORT >= (1 << 20) || LP_LONG >= (1 << 20) ||
      WAKE >= (1 << 20) || SRST < 1 || SRST > 16) begin : g_bad_count
    $error("phy_lpm_device: count parameter out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read view

  function automatic phy_lpm_pkg::mgmt_data_t read_reg(
    input phy_lpm_pkg::mgmt_addr_t a,
    input phy_lpm_pkg::dev_state_s st
  );
    phy_lpm_pkg::mgmt_data_t v;
    v = 16'h0000;
    case (a)
      `REG_BASIC_CTRL: begin
        v[`BIT_SOFT_RESET] = st.srst;
        v[`BIT_AUTONEG]    = st.an_en;
        v[`BIT_POWER_DOWN] = st.pd;
      end
      `REG_DIG_CTRL:  v[`BIT_PLL_OFF]  = st.pll_off;
      `REG_AFE_CTRL:  v[`BIT_SLOW_OSC] = st.slow;
      `REG_EXP_CTRL:  v[`BIT_EDM_DIS]  = st.edm_dis;
      `REG_PHY_CTRL2: v[`BIT_PWR_SAVE] = st.ps_en;
      default:        v = 16'h0000;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  phy_lpm_pkg::dev_state_s s_r;
  phy_lpm_pkg::dev_state_s s_nxt;
  logic                    lowpow_ok;
  logic                    edm_now;
  logic                    ps_now;
  phy_lpm_pkg::cnt_t       lp_limit;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.link_pulse = 1'b0;
    s_nxt.soft_reset = 1'b0;

    // both low-power modes need autoneg on and no link; a wake holds off
    lowpow_ok = s_r.an_en & ~link_up & ~s_r.wake & ~s_r.pd;
    edm_now   = ~s_r.edm_dis & lowpow_ok;
    // energy-detect mode is the deeper one and takes precedence
    ps_now    = s_r.ps_en & lowpow_ok & ~edm_now;

    // software reset: bit stays set while the reset runs, then clears
    if (s_r.srst) begin
      s_nxt.soft_reset = 1'b1;
      if (s_r.srst_cnt == 4'(SRST - 1)) begin
        s_nxt.srst     = 1'b0;
        s_nxt.srst_cnt = 4'h0;
        s_nxt.an_en    = `RST_AUTONEG;
        s_nxt.pd       = `RST_POWER_DOWN;
        s_nxt.pll_off  = `RST_PLL_OFF;
        s_nxt.slow     = `RST_SLOW_OSC;
        s_nxt.edm_dis  = `RST_EDM_DIS;
        s_nxt.ps_en    = `RST_PWR_SAVE;
      end else begin
        s_nxt.srst_cnt = s_r.srst_cnt + 4'h1;
      end
    end

    // management stays served in every mode; the clock select is only
    // changed from the register after the ack flop, so the access that
    // moves it finishes on the old settings
    if (mgmt.req && !s_r.ack) begin
      s_nxt.ack   = 1'b1;
      s_nxt.rdata = read_reg(mgmt.addr, s_r);
      if (mgmt.we) begin
        case (mgmt.addr)
          `REG_BASIC_CTRL: begin
            s_nxt.an_en = mgmt.wdata[`BIT_AUTONEG];
            s_nxt.pd    = mgmt.wdata[`BIT_POWER_DOWN];
            if (mgmt.wdata[`BIT_SOFT_RESET]) begin
              s_nxt.srst     = 1'b1;
              s_nxt.srst_cnt = 4'h0;
            end
          end
          `REG_DIG_CTRL:  s_nxt.pll_off  = mgmt.wdata[`BIT_PLL_OFF];
          `REG_AFE_CTRL:  s_nxt.slow     = mgmt.wdata[`BIT_SLOW_OSC];
          `REG_EXP_CTRL:  s_nxt.edm_dis  = mgmt.wdata[`BIT_EDM_DIS];
          `REG_PHY_CTRL2: s_nxt.ps_en    = mgmt.wdata[`BIT_PWR_SAVE];
          default: s_nxt.ack = 1'b1;
        endcase
      end
    end

    // line energy wakes the receiver; without a link it drops back later
    if (energy_detect && (s_r.ps_act || s_r.edm_act)) begin
      s_nxt.wake     = 1'b1;
      s_nxt.wake_cnt = '0;
    end else if (s_r.wake) begin
      if (link_up || s_r.wake_cnt == phy_lpm_pkg::cnt_t'(WAKE - 1)) begin
        s_nxt.wake     = 1'b0;
        s_nxt.wake_cnt = '0;
      end else begin
        s_nxt.wake_cnt = s_r.wake_cnt + 20'h00001;
      end
    end

    // link pulses keep a sleeping partner able to wake; the longer
    // interval goes with the pll off, trading wake latency for power
    lp_limit = s_r.pll_off ? phy_lpm_pkg::cnt_t'(LP_LONG - 1)
                           : phy_lpm_pkg::cnt_t'(LP_SHORT - 1);
    if (s_r.edm_act) begin
      if (s_r.lp_cnt >= lp_limit) begin
        s_nxt.link_pulse = 1'b1;
        s_nxt.lp_cnt     = '0;
      end else begin
        s_nxt.lp_cnt = s_r.lp_cnt + 20'h00001;
      end
    end else begin
      s_nxt.lp_cnt = '0;
    end

    s_nxt.ps_act   = ps_now;
    s_nxt.edm_act  = edm_now;
    s_nxt.func_en  = ~s_r.pd;
    s_nxt.tx_pwr   = ~s_r.pd;
    s_nxt.ed_pwr   = ~s_r.pd;
    s_nxt.pll_pwr  = ~s_r.pd & ~(edm_now & s_r.pll_off);
    s_nxt.rx_pwr   = ~s_r.pd & ~ps_now & ~edm_now;
    s_nxt.slow_sel = s_r.slow;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r            <= '0;
      s_r.an_en      <= `RST_AUTONEG;
      s_r.pd         <= `RST_POWER_DOWN;
      s_r.pll_off    <= `RST_PLL_OFF;
      s_r.slow       <= `RST_SLOW_OSC;
      s_r.edm_dis    <= `RST_EDM_DIS;
      s_r.ps_en      <= `RST_PWR_SAVE;
      s_r.func_en    <= 1'b1;
      s_r.tx_pwr     <= 1'b1;
      s_r.ed_pwr     <= 1'b1;
      s_r.pll_pwr    <= 1'b1;
      s_r.rx_pwr     <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign mgmt.ack            = s_r.ack;
  assign mgmt.rdata          = s_r.rdata;
  assign rx_power_en         = s_r.rx_pwr;
  assign tx_power_en         = s_r.tx_pwr;
  assign energy_det_power_en = s_r.ed_pwr;
  assign pll_power_en        = s_r.pll_pwr;
  assign core_func_en        = s_r.func_en;
  assign slow_osc_sel        = s_r.slow_sel;
  assign link_pulse          = s_r.link_pulse;
  assign soft_reset          = s_r.soft_reset;
  assign power_saving_active = s_r.ps_act;
  assign energy_detect_power_down = s_r.edm_act;

endmodule

// [core/phy_lpm_host.sv]
// management controller: apb command registers driving the link
`include "phy_lpm_params.svh"

module phy_lpm_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  mgmt_if.host             mgmt
);

  phy_lpm_pkg::host_state_s s_r;
  phy_lpm_pkg::host_state_s s_nxt;
  logic [31:0]              rd;
  logic                     hit;
  logic                     wr_take;

  always_comb begin
    s_nxt = s_r;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    hit = 1'b1;
    rd  = 32'h00000000;
    case (paddr)
      `APB_CMD_ADDR:  rd[4:0]  = s_r.cmd_addr;
      `APB_CMD_WDATA: rd[15:0] = s_r.cmd_wdata;
      `APB_CTRL:      rd[`CTRL_WRITE] = s_r.we;
      `APB_STATUS: begin
        rd[`STAT_BUSY] = (s_r.state == phy_lpm_pkg::H_WAIT);
        rd[`STAT_DONE] = s_r.done;
      end
      `APB_RDATA:     rd[15:0] = s_r.rdata;
      default:        hit = 1'b0;
    endcase

    // one wait state: pready rises in the second access cycle
    if (psel && penable && !s_r.pready) begin
      s_nxt.pready  = 1'b1;
      s_nxt.prdata  = pwrite ? 32'h00000000 : rd;
      s_nxt.pslverr = ~hit;
    end

    wr_take = psel & penable & s_r.pready & pwrite;
    if (wr_take) begin
      case (paddr)
        `APB_CMD_ADDR:  s_nxt.cmd_addr  = pwdata[4:0];
        `APB_CMD_WDATA: s_nxt.cmd_wdata = pwdata[15:0];
        `APB_CTRL: begin
          // a start while busy is dropped so the link request stays stable
          if (pwdata[`CTRL_START] && s_r.state == phy_lpm_pkg::H_IDLE) begin
            s_nxt.state = phy_lpm_pkg::H_WAIT;
            s_nxt.req   = 1'b1;
            s_nxt.we    = pwdata[`CTRL_WRITE];
            s_nxt.addr  = s_r.cmd_addr;
            s_nxt.wdata = s_r.cmd_wdata;
            s_nxt.done  = 1'b0;
          end
        end
        default: s_nxt.done = s_r.done;
      endcase
    end

    case (s_r.state)
      phy_lpm_pkg::H_IDLE: s_nxt.req = s_nxt.req;
      phy_lpm_pkg::H_WAIT: begin
        // exit order from lowest power is sequenced by software
        if (mgmt.ack) begin
          s_nxt.state = phy_lpm_pkg::H_IDLE;
          s_nxt.req   = 1'b0;
          s_nxt.rdata = mgmt.rdata;
          s_nxt.done  = 1'b1;
        end
      end
      default: s_nxt.state = phy_lpm_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata     = s_r.prdata;
  assign pready     = s_r.pready;
  assign pslverr    = s_r.pslverr;
  assign mgmt.req   = s_r.req;
  assign mgmt.we    = s_r.we;
  assign mgmt.addr  = s_r.addr;
  assign mgmt.wdata = s_r.wdata;

endmodule

// [tb/phy_lpm_sva.sv]
// link handshake and register read-back checks between the two ends
`include "phy_lpm_params.svh"
module phy_lpm_sva (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    req,
  input wire logic                    we,
  input wire phy_lpm_pkg::mgmt_addr_t addr,
  input wire phy_lpm_pkg::mgmt_data_t wdata,
  input wire logic                    ack,
  input wire phy_lpm_pkg::mgmt_data_t rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // shadow of two control bits; soft reset may lag, reads come later
  logic ps_r;
  logic ed_r;
  wire  take = req && !ack && we;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_r <= `RST_PWR_SAVE;
      ed_r <= `RST_EDM_DIS;
    end else if (take && addr == `REG_PHY_CTRL2) begin
      ps_r <= wdata[`BIT_PWR_SAVE];
    end else if (take && addr == `REG_EXP_CTRL) begin
      ed_r <= wdata[`BIT_EDM_DIS];
    end else if (take && addr == `REG_BASIC_CTRL
                 && wdata[`BIT_SOFT_RESET]) begin
      ps_r <= `RST_PWR_SAVE;
      ed_r <= `RST_EDM_DIS;
    end
  end
  ////////////////////////////////////////
  ack_follows_req_a: assert property (req && !ack |=> ack)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  ack_cause_a: assert property (ack |-> $past(req) && !$past(ack))
    else $error("answer without request");
  req_hold_a: assert property (req && !ack |=> req && $stable(addr)
    && $stable(we) && $stable(wdata))
    else $error("request changed before answer");
  req_release_a: assert property (ack |=> !req)
    else $error("request kept after answer");
  rdata_hold_a: assert property ($changed(rdata) |-> ack)
    else $error("read data moved without answer");
  save_readback_a: assert property (ack && !we
    && addr == `REG_PHY_CTRL2 |-> rdata[`BIT_PWR_SAVE] == ps_r)
    else $error("power saving bit reads wrong");
  edm_readback_a: assert property (ack && !we
    && addr == `REG_EXP_CTRL |-> rdata[`BIT_EDM_DIS] == ed_r)
    else $error("energy detect bit reads wrong");
  cover property (ack && we);
  cover property (ack && !we);
  cover property (ack && we && addr == `REG_AFE_CTRL
                  && wdata[`BIT_SLOW_OSC]);
endmodule

// [tb/testbench.sv]
// bench: apb drives the controller, which programs the transceiver
`include "phy_lpm_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        link_up;
  logic        energy_detect;
  logic        rx_power_en;
  logic        tx_power_en;
  logic        energy_det_power_en;
  logic        pll_power_en;
  logic        core_func_en;
  logic        slow_osc_sel;
  logic        link_pulse;
  logic        soft_reset;
  logic        power_saving_active;
  logic        energy_detect_power_down;
  int          error_cnt;
  int          cmp_count;
  int          lp_n;
  logic        sr_seen;
  logic        err_r;
  logic [31:0] seed;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  wire  [7:0]  pw = {rx_power_en, tx_power_en, energy_det_power_en,
                     pll_power_en, core_func_en, slow_osc_sel,
                     power_saving_active, energy_detect_power_down};
  mgmt_if lnk();
  phy_lpm_host phy_lpm_host_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mgmt(lnk));
  phy_lpm_device #(.LP_SHORT(4), .LP_LONG(8), .WAKE(8), .SRST(4))
    phy_lpm_device_inst (.pclk, .presetn, .mgmt(lnk), .link_up,
    .energy_detect, .rx_power_en, .tx_power_en, .energy_det_power_en,
    .pll_power_en, .core_func_en, .slow_osc_sel, .link_pulse, .soft_reset,
    .power_saving_active, .energy_detect_power_down);
  phy_lpm_sva phy_lpm_sva_inst (.pclk, .presetn, .req(lnk.req),
    .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack),
    .rdata(lnk.rdata));
  ////////////////////////////////////////
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t read %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_out(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t outputs %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed here: only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err_r = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one link transfer, polled to completion
  task automatic mg(input logic w, input logic [4:0] a, input logic [15:0] d);
    logic [31:0] r;
    apb(1'b1, `APB_CMD_ADDR, {27'h0, a}, r);
    apb(1'b1, `APB_CMD_WDATA, {16'h0, d}, r);
    apb(1'b1, `APB_CTRL, {30'h0, w, 1'b1}, r);
    do begin
      apb(1'b0, `APB_STATUS, 32'h0, r);
    end while (r[`STAT_DONE] !== 1'b1);
    repeat (3) @(posedge pclk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e,
                    input logic [15:0] m);
    logic [31:0] r;
    mg(1'b0, a, 16'h0);
    exp_q.push_back({16'h0, e});
    msk_q.push_back({16'h0, m});
    apb(1'b0, `APB_RDATA, 32'h0, r);
  endtask
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite
        && paddr == `APB_RDATA && exp_q.size() > 0)
      cmp_rd(prdata & msk_q.pop_front(), exp_q.pop_front());
    if (soft_reset === 1'b1)
      sr_seen <= 1'b1;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    end_sim();
  end
  initial begin
    logic [31:0] r;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, link_up, energy_detect, sr_seen} = '0;
    seed = 32'hd1e6;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`REG_PHY_CTRL2, 16'h0000, 16'h0400);
    rd(`REG_EXP_CTRL, 16'h0800, 16'h0800);
    cmp_out(pw, 8'hf8);
    apb(1'b0, 12'h0ff, 32'h0, r);
    cmp_out({7'h0, err_r}, 8'h01);
    $display("test reset done");
    mg(1'b1, `REG_PHY_CTRL2, 16'h0400);
    cmp_out(pw, 8'h7a);
    link_up <= 1'b1;
    repeat (3) @(posedge pclk);
    cmp_out(pw, 8'hf8);
    link_up <= 1'b0;
    repeat (3) @(posedge pclk);
    cmp_out(pw, 8'h7a);
    energy_detect <= 1'b1;
    repeat (3) @(posedge pclk);
    cmp_out(pw, 8'hf8);
    energy_detect <= 1'b0;
    repeat (15) @(posedge pclk);
    cmp_out(pw, 8'h7a);
    mg(1'b1, `REG_PHY_CTRL2, 16'h0000);
    $display("test power saving done");
    mg(1'b1, `REG_EXP_CTRL, 16'h0000);
    cmp_out(pw, 8'h79);
    mg(1'b1, `REG_DIG_CTRL, 16'h0010);
    cmp_out(pw, 8'h69);
    repeat (10) @(posedge pclk);
    // counted here, not in the monitor, so the window is exactly 40 edges
    lp_n = 0;
    repeat (40) begin
      @(posedge pclk);
      if (link_pulse === 1'b1)
        lp_n++;
    end
    cmp_out(8'(lp_n), 8'h05);
    mg(1'b1, `REG_BASIC_CTRL, 16'h0000);
    cmp_out(pw, 8'hf8);
    mg(1'b1, `REG_BASIC_CTRL, 16'h1000);
    mg(1'b1, `REG_EXP_CTRL, 16'h0800);
    mg(1'b1, `REG_DIG_CTRL, 16'h0000);
    $display("test energy detect done");
    mg(1'b1, `REG_BASIC_CTRL, 16'h1800);
    cmp_out(pw, 8'h00);
    r = $random(seed);
    mg(1'b1, `REG_PHY_CTRL2, r[15:0] | 16'h0400);
    rd(`REG_PHY_CTRL2, 16'h0400, 16'h0400);
    mg(1'b1, `REG_AFE_CTRL, 16'h0020);
    cmp_out(pw, 8'h04);
    mg(1'b1, `REG_AFE_CTRL, 16'h0000);
    cmp_out(pw, 8'h00);
    mg(1'b1, `REG_BASIC_CTRL, 16'h1000);
    cmp_out(pw, 8'h7a);
    mg(1'b1, `REG_BASIC_CTRL, 16'h9000);
    repeat (10) @(posedge pclk);
    cmp_out({7'h0, sr_seen}, 8'h01);
    cmp_out(pw, 8'hf8);
    rd(`REG_BASIC_CTRL, 16'h1000, 16'h9800);
    rd(`REG_PHY_CTRL2, 16'h0000, 16'h0400);
    $display("test power down done");
    end_sim();
  end
endmodule
